// ==== hw/bcw_pkg.sv ====
// Package for brightness readout, calibration and walking test block
package bcw_pkg;

    // Bus and data widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int BRIGHT_W = 16;
    localparam int SCALE_FRAC = 8;
    localparam int SECTORS = 3;
    localparam int SENS_W = 2;
    localparam int SLOTS = 5;
    localparam int TIMER_W = 16;
    localparam int DIV_STEPS = BRIGHT_W + SCALE_FRAC;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_THRESH = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CYCLE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CALIB = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_BRIGHT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SECTOR = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_DOWNLOAD = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_DELAY = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_SCALE = 8'h24;

    // Control register layout, high bit first: calib_telegram at bit 0
    typedef struct packed {
        logic ir_test_en;
        logic [1:0] send_mode;
        logic walk_after_prog;
        logic led_normal;
        logic pend_invalid;
        logic calib_telegram;
    } bcw_ctrl_t;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam int SEND_CHANGE_BIT = 0;
    localparam int SEND_CYCLIC_BIT = 1;

    // Download word: positions of the new calibration and walking test settings
    localparam int DL_CALIB_BIT = 0;
    localparam int DL_WALK_BIT = 3;

    // Sector register layout: assignment mask then two sensitivity bits per sector
    typedef struct packed {
        logic [SECTORS*SENS_W-1:0] sens;
        logic [SECTORS-1:0] assigned;
    } bcw_sector_t;
    localparam int SECTOR_REG_W = 9;
    localparam logic [SECTOR_REG_W-1:0] SECTOR_RST = 9'h001;

    // Status register bit positions
    localparam int ST_WALK = 0;
    localparam int ST_CALIB_VALID = 1;
    localparam int ST_PENDING = 2;
    localparam int ST_MOTION_DLY = 3;
    localparam int ST_RETURN_DLY = 4;
    localparam int ST_DIV_BUSY = 5;

    // Other reset values
    localparam logic [TIMER_W-1:0] THRESH_RST = 16'h0010;
    localparam logic [TIMER_W-1:0] CYCLE_RST = 16'h03E8;
    localparam logic [TIMER_W-1:0] DELAY_RST = 16'h2710;

    // Brightness conversion; scale is unsigned Q8.8, surface = sensor * scale
    localparam real REFL_DEFAULT = 0.3;
    localparam logic [BRIGHT_W-1:0] SCALE_DEFAULT = 16'(int'(256.0 / REFL_DEFAULT));
    localparam logic [BRIGHT_W-1:0] SCALE_SAT = 16'hFFFF;
    localparam logic [BRIGHT_W-1:0] BRIGHT_PEND_ZERO = 16'h0000;
    localparam logic [BRIGHT_W-1:0] BRIGHT_INVALID = 16'h7FFF;
    localparam logic [BRIGHT_W-1:0] BRIGHT_MAX = 16'h7FFE;

    // Millisecond tick
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic {WALK_OFF, WALK_ON} bcw_walk_t;
    typedef enum logic {DIV_IDLE, DIV_RUN} bcw_div_t;

endpackage

// ==== hw/bcw_brightness_walk.sv ====
// Brightness readout with user calibration and walking test control
`timescale 1ns/1ps
`default_nettype none

module bcw_brightness_walk
    import bcw_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [BRIGHT_W-1:0] sensor_bright_i,
    input wire logic bright_req_i,
    input wire logic [SECTORS-1:0] sector_motion_i,
    input wire logic supply_fail_i,
    input wire logic ir_test_i,
    input wire logic ir_sens_i,
    input wire logic ir_other_i,
    input wire logic [SLOTS-1:0] fb_disable_i,
    output logic [BRIGHT_W-1:0] bright_value_o,
    output logic bright_send_o,
    output logic status_lamp_o,
    output logic [SECTORS-1:0] sector_enable_o,
    output logic [SECTORS*SENS_W-1:0] sector_sens_o,
    output logic brightness_dep_o,
    output logic fb_process_en_o,
    output logic group_switch_en_o,
    output logic light_ctrl_en_o,
    output logic standalone_o,
    output logic return_behav_en_o,
    output logic prog_behav_en_o,
    output logic [SLOTS-1:0] fb_disable_o,
    output logic ir_sens_o,
    output logic ir_other_o,
    output logic fb_basic_state_o,
    output logic motion_delay_o,
    output logic return_delay_o
);

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int STEP_W = $clog2(DIV_STEPS + 1);

    // Register state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [SECTOR_REG_W-1:0] sector_reg;
    logic [TIMER_W-1:0] thresh_reg;
    logic [TIMER_W-1:0] cycle_reg;
    logic [TIMER_W-1:0] delay_reg;
    logic [BRIGHT_W-1:0] scale_reg;
    logic calib_valid_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [DATA_W-1:0] prdata_reg;
    bcw_ctrl_t ctrl;
    bcw_sector_t sector;
    assign ctrl = bcw_ctrl_t'(ctrl_reg);
    assign sector = bcw_sector_t'(sector_reg);

    // Pin synchronisers: first stage feeds only the second
    logic [SECTORS-1:0] motion_meta_reg;
    logic [SECTORS-1:0] motion_sync_reg;
    logic fail_meta_reg;
    logic fail_sync_reg;
    always_ff @(posedge clock_i) begin
        motion_meta_reg <= sector_motion_i;
        motion_sync_reg <= motion_meta_reg;
        fail_meta_reg <= supply_fail_i;
        fail_sync_reg <= fail_meta_reg;
    end

    // Supply loss acts as a device reset for outputs except return_delay_o, and for the walking test and motion delay, not for configuration, calibration or bus logic
    logic fail_prev_reg;
    wire dev_reset = reset_i | fail_sync_reg;
    wire supply_return = fail_prev_reg & ~fail_sync_reg;
    always_ff @(posedge clock_i) begin
        fail_prev_reg <= reset_i ? 1'b0 : fail_sync_reg;
    end

    // APB decode; a write or read completes when pready is already high
    wire apb_access = psel_i & penable_i;
    wire apb_done = apb_access & pready_reg;
    wire apb_wr = apb_done & pwrite_i;
    wire hit_ctrl = paddr_i == OFS_CTRL;
    wire hit_thresh = paddr_i == OFS_THRESH;
    wire hit_cycle = paddr_i == OFS_CYCLE;
    wire hit_calib = paddr_i == OFS_CALIB;
    wire hit_bright = paddr_i == OFS_BRIGHT;
    wire hit_status = paddr_i == OFS_STATUS;
    wire hit_sector = paddr_i == OFS_SECTOR;
    wire hit_download = paddr_i == OFS_DOWNLOAD;
    wire hit_delay = paddr_i == OFS_DELAY;
    wire hit_scale = paddr_i == OFS_SCALE;
    wire hit_any = hit_ctrl | hit_thresh | hit_cycle | hit_calib | hit_bright | hit_status
        | hit_sector | hit_download | hit_delay | hit_scale;
    wire download_wr = apb_wr & hit_download;

    // Walking test and divider state machines
    bcw_walk_t walk_reg;
    bcw_walk_t walk_next;
    bcw_div_t div_reg;
    logic [TIMER_W-1:0] ret_cnt_reg;
    logic [TIMER_W-1:0] mot_cnt_reg;
    logic [BRIGHT_W-1:0] bright_reg;
    wire walk = walk_reg == WALK_ON;
    wire pending = ctrl.calib_telegram & ~calib_valid_reg;
    wire calib_wr = apb_wr & hit_calib & ctrl.calib_telegram;
    wire [DATA_W-1:0] status_word = {{(DATA_W-6){1'b0}}, div_reg == DIV_RUN,
        ret_cnt_reg != '0, mot_cnt_reg != '0, pending, calib_valid_reg, walk};

    // Read mux; unmapped addresses read zero and flag an error
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (1'b1)
            hit_ctrl: rd_mux = DATA_W'(ctrl_reg);
            hit_thresh: rd_mux = DATA_W'(thresh_reg);
            hit_cycle: rd_mux = DATA_W'(cycle_reg);
            hit_bright: rd_mux = DATA_W'(bright_reg);
            hit_status: rd_mux = status_word;
            hit_sector: rd_mux = DATA_W'(sector_reg);
            hit_delay: rd_mux = DATA_W'(delay_reg);
            hit_scale: rd_mux = DATA_W'(scale_reg);
            default: rd_mux = '0;
        endcase
    end

    // One wait cycle: pready rises in the second access cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= apb_access & ~pready_reg;
            pslverr_reg <= apb_access & ~pready_reg & ~hit_any;
            if (apb_access & ~pready_reg) begin
                prdata_reg <= pwrite_i ? '0 : rd_mux;
            end
        end
    end

    // Configuration registers; a supply loss does not erase the configuration
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_reg <= CTRL_RST;
            sector_reg <= SECTOR_RST;
            thresh_reg <= THRESH_RST;
            cycle_reg <= CYCLE_RST;
            delay_reg <= DELAY_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) ctrl_reg <= pwdata_i[CTRL_W-1:0];
            if (hit_sector) sector_reg <= pwdata_i[SECTOR_REG_W-1:0];
            if (hit_thresh) thresh_reg <= pwdata_i[TIMER_W-1:0];
            if (hit_cycle) cycle_reg <= pwdata_i[TIMER_W-1:0];
            if (hit_delay) delay_reg <= pwdata_i[TIMER_W-1:0];
        end
    end

    // Calibration divider: scale = (reference << 8) / sensor, restoring, one bit per cycle
    logic [DIV_STEPS-1:0] quo_reg;
    logic [BRIGHT_W:0] rem_reg;
    logic [BRIGHT_W-1:0] divisor_reg;
    logic [STEP_W-1:0] step_reg;
    wire [BRIGHT_W:0] rem_shift = {rem_reg[BRIGHT_W-1:0], quo_reg[DIV_STEPS-1]};
    wire rem_ge = rem_shift >= {1'b0, divisor_reg};
    wire div_last = step_reg == STEP_W'(DIV_STEPS - 1);
    wire quo_ovf = |quo_reg[DIV_STEPS-1:BRIGHT_W-1];
    wire [BRIGHT_W-1:0] quo_final = {quo_reg[BRIGHT_W-2:0], rem_ge};
    wire [BRIGHT_W-1:0] scale_calc = (divisor_reg == '0 || quo_ovf) ? SCALE_SAT : quo_final;

    // A later reference restarts the division so the newest one wins
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            div_reg <= DIV_IDLE;
            step_reg <= '0;
            quo_reg <= '0;
            rem_reg <= '0;
            divisor_reg <= '0;
        end else if (calib_wr) begin
            div_reg <= DIV_RUN;
            step_reg <= '0;
            quo_reg <= {pwdata_i[BRIGHT_W-1:0], {SCALE_FRAC{1'b0}}};
            rem_reg <= '0;
            divisor_reg <= sensor_bright_i;
        end else if (div_reg == DIV_RUN) begin
            rem_reg <= rem_ge ? rem_shift - {1'b0, divisor_reg} : rem_shift;
            quo_reg <= {quo_reg[DIV_STEPS-2:0], rem_ge};
            step_reg <= step_reg + 1'b1;
            if (div_last) div_reg <= DIV_IDLE;
        end
    end

    // Scale store survives supply loss; a finishing division wins a tie with a download
    wire div_finish = div_reg == DIV_RUN && div_last && !calib_wr;
    wire factory_dl = download_wr & ~pwdata_i[DL_CALIB_BIT] & ~ctrl.calib_telegram;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            scale_reg <= SCALE_DEFAULT;
            calib_valid_reg <= 1'b0;
        end else if (div_finish) begin
            scale_reg <= scale_calc;
            calib_valid_reg <= 1'b1;
        end else if (factory_dl) begin
            scale_reg <= SCALE_DEFAULT;
            calib_valid_reg <= 1'b0;
        end
    end

    // Surface brightness; saturates below the invalid marker
    wire [2*BRIGHT_W-1:0] product = sensor_bright_i * scale_reg;
    wire [BRIGHT_W-1:0] prod_q = product[BRIGHT_W+SCALE_FRAC-1:SCALE_FRAC];
    wire prod_big = |product[2*BRIGHT_W-1:BRIGHT_W+SCALE_FRAC] || prod_q > BRIGHT_MAX;
    wire [BRIGHT_W-1:0] surface = prod_big ? BRIGHT_MAX : prod_q;
    wire [BRIGHT_W-1:0] pend_value = ctrl.pend_invalid ? BRIGHT_INVALID : BRIGHT_PEND_ZERO;
    wire [BRIGHT_W-1:0] bright_next = pending ? pend_value : surface;

    // Millisecond tick divider
    logic [TICK_W-1:0] tick_cnt_reg;
    wire tick = tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
    always_ff @(posedge clock_i) begin
        if (reset_i || tick) tick_cnt_reg <= '0;
        else tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    // Publication on change, cyclic or on request
    logic [BRIGHT_W-1:0] last_sent_reg;
    logic [TIMER_W-1:0] cyc_cnt_reg;
    logic send_reg;
    wire [BRIGHT_W-1:0] diff = (bright_next > last_sent_reg) ? bright_next - last_sent_reg
        : last_sent_reg - bright_next;
    wire change_hit = ctrl.send_mode[SEND_CHANGE_BIT] && thresh_reg != '0 && diff >= thresh_reg;
    wire cyc_hit = ctrl.send_mode[SEND_CYCLIC_BIT] && tick && cyc_cnt_reg + 1'b1 >= cycle_reg;
    wire send_now = change_hit | cyc_hit | bright_req_i;
    always_ff @(posedge clock_i) begin
        if (dev_reset) begin
            bright_reg <= BRIGHT_PEND_ZERO;
            last_sent_reg <= BRIGHT_PEND_ZERO;
            cyc_cnt_reg <= '0;
            send_reg <= 1'b0;
        end else begin
            bright_reg <= bright_next;
            send_reg <= send_now;
            if (send_now) last_sent_reg <= bright_next;
            if (cyc_hit) cyc_cnt_reg <= '0;
            else if (tick) cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
        end
    end

    // Walking test entry and exit
    wire ir_toggle = ir_test_i & ctrl.ir_test_en;
    always_comb begin
        walk_next = walk_reg;
        if (download_wr) begin
            walk_next = pwdata_i[DL_WALK_BIT] | ctrl.walk_after_prog ? WALK_ON : WALK_OFF;
        end else if (ir_toggle) begin
            walk_next = walk ? WALK_OFF : WALK_ON;
        end
    end
    wire walk_enter = !walk && walk_next == WALK_ON;
    wire walk_exit_ir = walk && ir_toggle && !download_wr;

    // Supply loss leaves the test; download and handset move it
    always_ff @(posedge clock_i) begin
        if (dev_reset) walk_reg <= WALK_OFF;
        else walk_reg <= walk_next;
    end

    // Combined motion of all sectors
    logic motion_prev_reg;
    wire motion_any = |motion_sync_reg;
    wire motion_end = motion_prev_reg & ~motion_any;
    always_ff @(posedge clock_i) begin
        motion_prev_reg <= dev_reset ? 1'b0 : motion_any;
    end

    // Transmission delay after motion end; never started while the test runs
    wire slots_active = !walk && !pending;
    always_ff @(posedge clock_i) begin
        if (dev_reset || walk_enter || walk_exit_ir) begin
            mot_cnt_reg <= '0;
        end else if (motion_end && slots_active) begin
            mot_cnt_reg <= delay_reg;
        end else if (tick && mot_cnt_reg != '0) begin
            mot_cnt_reg <= mot_cnt_reg - 1'b1;
        end
    end

    // Delay after supply return; cancelled for good on entering the test
    always_ff @(posedge clock_i) begin
        if (reset_i || walk_enter || walk) begin
            ret_cnt_reg <= '0;
        end else if (supply_return) begin
            ret_cnt_reg <= delay_reg;
        end else if (tick && ret_cnt_reg != '0) begin
            ret_cnt_reg <= ret_cnt_reg - 1'b1;
        end
    end

    // Lamp and sector control
    wire lamp_next = motion_any & (walk | ctrl.led_normal);
    wire [SECTORS-1:0] sect_en_next = walk ? {SECTORS{1'b1}} : sector.assigned;
    always_ff @(posedge clock_i) begin
        if (dev_reset) begin
            status_lamp_o <= 1'b0;
            sector_enable_o <= SECTOR_RST[SECTORS-1:0];
            sector_sens_o <= '0;
        end else begin
            status_lamp_o <= lamp_next;
            sector_enable_o <= sect_en_next;
            sector_sens_o <= sector.sens;
        end
    end

    // Handset filtering: only test and sensitivity pass during the test
    wire ir_other_next = ir_other_i & ~walk;
    wire basic_next = walk_exit_ir & ~pending;

    // Slot and system enables
    always_ff @(posedge clock_i) begin
        if (dev_reset) begin
            brightness_dep_o <= 1'b1;
            fb_process_en_o <= 1'b0;
            group_switch_en_o <= 1'b1;
            light_ctrl_en_o <= 1'b0;
            standalone_o <= 1'b0;
            return_behav_en_o <= 1'b1;
            prog_behav_en_o <= 1'b1;
            fb_disable_o <= '0;
            ir_sens_o <= 1'b0;
            ir_other_o <= 1'b0;
            fb_basic_state_o <= 1'b0;
        end else begin
            brightness_dep_o <= ~walk;
            fb_process_en_o <= slots_active;
            group_switch_en_o <= ~walk;
            light_ctrl_en_o <= ~pending;
            standalone_o <= walk;
            return_behav_en_o <= ~walk;
            prog_behav_en_o <= ~walk;
            fb_disable_o <= walk ? '0 : fb_disable_i;
            ir_sens_o <= ir_sens_i;
            ir_other_o <= ir_other_next;
            fb_basic_state_o <= basic_next;
        end
    end

    // Delay flags registered so both ports come straight from flip-flops
    logic mot_busy_reg;
    logic ret_busy_reg;
    always_ff @(posedge clock_i) begin
        mot_busy_reg <= ~reset_i & (mot_cnt_reg != '0);
        ret_busy_reg <= ~reset_i & (ret_cnt_reg != '0);
    end

    // Registered outputs
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign bright_value_o = bright_reg;
    assign bright_send_o = send_reg;
    assign motion_delay_o = mot_busy_reg;
    assign return_delay_o = ret_busy_reg;

endmodule

`default_nettype wire

// ==== tb/bcw_brightness_walk_sva.sv ====
// Checker for the walking test outputs of the brightness block
`timescale 1ns/1ps
`default_nettype none
module bcw_brightness_walk_chk
    import bcw_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [SECTORS-1:0] sector_motion_i,
    input wire logic ir_sens_i,
    input wire logic ir_other_i,
    input wire logic bright_req_i,
    input wire logic bright_send_o,
    input wire logic status_lamp_o,
    input wire logic [SECTORS-1:0] sector_enable_o,
    input wire logic brightness_dep_o,
    input wire logic fb_process_en_o,
    input wire logic group_switch_en_o,
    input wire logic standalone_o,
    input wire logic return_behav_en_o,
    input wire logic prog_behav_en_o,
    input wire logic [SLOTS-1:0] fb_disable_o,
    input wire logic ir_sens_o,
    input wire logic ir_other_o,
    input wire logic fb_basic_state_o,
    input wire logic motion_delay_o,
    input wire logic return_delay_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // Standalone output marks the walking test at the ports
    walk_sectors_a: assert property (standalone_o |-> sector_enable_o == 3'h7)
        else $error("sectors not all enabled in walk test");
    walk_no_slots_a: assert property (standalone_o |-> !fb_process_en_o && !group_switch_en_o)
        else $error("slot processing active in walk test");
    walk_indep_a: assert property (standalone_o |-> !brightness_dep_o)
        else $error("brightness dependence in walk test");
    walk_ignores_a: assert property (standalone_o |->
        !return_behav_en_o && !prog_behav_en_o && fb_disable_o == 5'h00)
        else $error("walk test still honours behaviour settings");
    // Lamp follows the ORed sectors after two sync stages and one register
    walk_lamp_a: assert property (standalone_o && $past(standalone_o, 4)
        |-> status_lamp_o == (|$past(sector_motion_i, 3)))
        else $error("lamp does not follow combined motion");
    ir_block_a: assert property (standalone_o && ir_other_i ##1 standalone_o |-> !ir_other_o)
        else $error("other handset key passed in walk test");
    ir_sens_pass_a: assert property (ir_sens_i |=> ir_sens_o)
        else $error("sensitivity key not passed");
    req_send_a: assert property (bright_req_i |=> bright_send_o)
        else $error("no send after request");
    walk_no_delay_a: assert property (standalone_o |-> !motion_delay_o && !return_delay_o)
        else $error("delay running in walk test");
    exit_basic_a: assert property (fb_basic_state_o |=> !fb_basic_state_o && !standalone_o)
        else $error("basic state pulse wrong");
    walk_lamp_c: cover property (standalone_o && status_lamp_o);
    exit_c: cover property (fb_basic_state_o);
    send_c: cover property (bright_send_o);
endmodule
bind bcw_brightness_walk bcw_brightness_walk_chk chk (.*);
`default_nettype wire

// ==== tb/bcw_peer_model.sv ====
// Handset decoder and bus peer model: one-cycle command pulses
`timescale 1ns/1ps
`default_nettype none
module bcw_peer_model (
    input wire logic clock_i,
    input wire logic [1:0] key_i,
    input wire logic go_i,
    output logic ir_test_o,
    output logic ir_sens_o,
    output logic ir_other_o,
    output logic req_o
);
    // A decoder never holds a key as a level, so each command is one pulse
    always_ff @(posedge clock_i) begin
        ir_test_o <= go_i && key_i == 2'h0;
        ir_sens_o <= go_i && key_i == 2'h1;
        ir_other_o <= go_i && key_i == 2'h2;
        req_o <= go_i && key_i == 2'h3;
    end
endmodule
`default_nettype wire

// ==== tb/bcw_brightness_walk_bench.sv ====
// Self-checking bench for brightness calibration and walking test
`timescale 1ns/1ps
`default_nettype none
module bcw_brightness_walk_bench
    import bcw_pkg::*;
;
    logic clock_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic bright_req_i, supply_fail_i, ir_test_i, ir_sens_i, ir_other_i;
    logic bright_send_o, status_lamp_o, brightness_dep_o, fb_process_en_o;
    logic group_switch_en_o, light_ctrl_en_o, standalone_o, return_behav_en_o;
    logic prog_behav_en_o, ir_sens_o, ir_other_o, fb_basic_state_o;
    logic motion_delay_o, return_delay_o, key_go, err;
    logic [1:0] key;
    logic [ADDR_W-1:0] paddr_i;
    logic [DATA_W-1:0] pwdata_i, prdata_o, rd;
    logic [BRIGHT_W-1:0] sensor_bright_i, bright_value_o;
    logic [SECTORS-1:0] sector_motion_i, sector_enable_o;
    logic [SECTORS*SENS_W-1:0] sector_sens_o;
    logic [SLOTS-1:0] fb_disable_i, fb_disable_o;
    int n_errors = 0;
    int compares = 0;
    // Short tick keeps millisecond counts cheap
    bcw_brightness_walk #(.TICK_CYCLES(10)) dut (.*);
    bcw_peer_model peer (.clock_i(clock_i), .key_i(key), .go_i(key_go), .ir_test_o(ir_test_i),
        .ir_sens_o(ir_sens_i), .ir_other_o(ir_other_i), .req_o(bright_req_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        chk(n, 32'h2, "wait states");
        // Idle edge so a following call never drives psel twice in one step
        @(posedge clock_i);
    endtask
    task automatic send(input logic [1:0] k);
        key <= k;
        key_go <= 1'b1;
        @(posedge clock_i);
        key_go <= 1'b0;
        tick(4);
    endtask
    task automatic t_factory;
        tick(4);
        chk(bright_value_o, 32'h3E7, "default factor");
        apb(1'b0, OFS_SCALE, 32'h0);
        chk(rd, 32'h355, "default scale");
        apb(1'b0, 8'h40, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
        send(2'h3);
    endtask
    task automatic t_calib;
        apb(1'b1, OFS_CTRL, 32'h3);
        tick(3);
        chk(bright_value_o, 32'h7FFF, "pending invalid");
        chk(light_ctrl_en_o, 32'h0, "light off pending");
        apb(1'b1, OFS_CTRL, 32'h1);
        tick(3);
        chk(bright_value_o, 32'h0, "pending zero");
        apb(1'b1, OFS_CALIB, 32'h258);
        tick(30);
        chk(bright_value_o, 32'h258, "calibrated");
        chk(light_ctrl_en_o, 32'h1, "light on");
        apb(1'b1, OFS_CALIB, 32'h96);
        tick(30);
        chk(bright_value_o, 32'h96, "recalibrated");
    endtask
    task automatic t_factory_back;
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CALIB, 32'h384);
        tick(30);
        chk(bright_value_o, 32'h96, "calib refused");
        apb(1'b1, OFS_DOWNLOAD, 32'h0);
        tick(30);
        chk(bright_value_o, 32'h3E7, "factory again");
    endtask
    task automatic t_walk;
        apb(1'b1, OFS_CTRL, 32'h44);
        apb(1'b1, OFS_SECTOR, 32'h1B1);
        apb(1'b1, OFS_DOWNLOAD, 32'h8);
        tick(3);
        chk(standalone_o, 32'h1, "walk entered");
        chk(sector_enable_o, 32'h7, "all sectors");
        chk(sector_sens_o, 32'h36, "sector sensitivity");
        chk(fb_process_en_o, 32'h0, "slots held");
        chk({group_switch_en_o, brightness_dep_o}, 32'h0, "group and dep off");
        chk({return_behav_en_o, prog_behav_en_o}, 32'h0, "behaviour off");
        chk(fb_disable_o, 32'h0, "disables ignored");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h1, "status walk");
        sector_motion_i <= 3'h4;
        tick(5);
        chk(status_lamp_o, 32'h1, "lamp on");
        sector_motion_i <= 3'h0;
        tick(5);
        chk({status_lamp_o, motion_delay_o}, 32'h0, "lamp off");
        send(2'h2);
        send(2'h1);
        send(2'h0);
        chk(standalone_o, 32'h0, "handset exit");
        chk({fb_disable_o, sector_enable_o}, 32'hF9, "normal disables");
        chk({return_behav_en_o, prog_behav_en_o}, 32'h3, "behaviour back");
        sector_motion_i <= 3'h1;
        tick(5);
        chk(status_lamp_o, 32'h1, "lamp normal op");
        sector_motion_i <= 3'h0;
        tick(5);
        chk(motion_delay_o, 32'h1, "delay after motion");
    endtask
    task automatic t_supply;
        apb(1'b1, OFS_DOWNLOAD, 32'h8);
        tick(3);
        supply_fail_i <= 1'b1;
        tick(5);
        chk(standalone_o, 32'h0, "supply exit");
        supply_fail_i <= 1'b0;
        apb(1'b1, OFS_DOWNLOAD, 32'h0);
        tick(3);
        chk(standalone_o, 32'h0, "download off");
        chk(return_delay_o, 32'h1, "return delay runs");
        apb(1'b1, OFS_DOWNLOAD, 32'h8);
        tick(3);
        chk(return_delay_o, 32'h0, "return delay cancelled");
        send(2'h0);
        chk({standalone_o, return_delay_o}, 32'h0, "delay stays off");
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence; sensor fixed at 300 so every expectation is exact
    initial begin
        reset_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        sensor_bright_i = 16'h012C;
        sector_motion_i = 3'h0;
        supply_fail_i = 1'b0;
        fb_disable_i = 5'h1F;
        key = 2'h0;
        key_go = 1'b0;
        tick(3);
        reset_i <= 1'b0;
        t_factory();
        t_calib();
        t_factory_back();
        t_walk();
        t_supply();
        end_of_test();
    end
    // Whole run needs well under two thousand cycles
    initial begin
        tick(5000);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
